// ---- src/pwc_pkg.sv ----
// Package for the PLL and wait-mode clock control block.
// Assumes an APB master with 32-bit data and one aligned word per register.
// Notes on behaviour
// - Tick timer wait-stop halts and resets dividers
// - Watchdog wait-stop halts and resets dividers
// - Watchdog wait-stop write-once in normal modes
// - Monitor enable locked while self-clock flag set
// - Enabled monitor detects loss, reset or self-clock
// - Full stop disables monitor regardless of enable
// - PLL power locked while PLL clock selected
// - Self-clock forces PLL on, read shows latch
// - Powered PLL with automatic bandwidth locks itself
// - Automatic mode picks bandwidth, else acquisition bit
// - Automatic bit locked and forced by wait-stop
// - Acquisition bit: zero low, one high bandwidth
// - PLL control resets to 1111_0001 pattern
package pwc_pkg;
  localparam logic [11:0] PWC_PLL_CONTROL_OFS  = 12'h000;
  localparam logic [11:0] PWC_WAIT_CONTROL_OFS = 12'h004;
  localparam logic [11:0] PWC_STATUS_OFS       = 12'h008;
  localparam logic [11:0] PWC_IRQ_STATUS_OFS   = 12'h00c;
  localparam logic [11:0] PWC_IRQ_MASK_OFS     = 12'h010;
  localparam logic [7:0]  PWC_PLL_CONTROL_RST  = 8'hf1;
  localparam logic [2:0]  PWC_WAIT_CONTROL_RST = 3'h0;
  // pll_control fields
  localparam int PWC_MON_BIT  = 7;
  localparam int PWC_PON_BIT  = 6;
  localparam int PWC_AUTO_BIT = 5;
  localparam int PWC_BW_BIT   = 4;
  localparam int PWC_PSW_BIT  = 2;
  localparam int PWC_SELF_BIT = 0;
  localparam logic [7:0] PWC_PLL_CONTROL_WMASK = 8'hf5;
  // wait control fields
  localparam int PWC_WDW_BIT  = 0;
  localparam int PWC_TTW_BIT  = 1;
  localparam int PWC_PWAI_BIT = 2;
  // interrupt events
  localparam int PWC_EV_LOSS  = 0;
  localparam int PWC_EV_LOCK  = 1;
  localparam int PWC_EV_WAIT  = 2;
  localparam int PWC_EV_N     = 3;
  typedef enum logic [1:0] {
    PWC_RUN  = 2'b00,
    PWC_WAIT = 2'b01,
    PWC_STOP = 2'b11
  } pwc_pmode_e;
endpackage

// ---- src/pwc_ctrl.sv ----
// PLL and wait-mode clock control: register file, PLL controls, wait stops.
// Assumes APB master on pclk; mode and analogue status inputs synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module pwc_ctrl (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Device mode
  input  wire logic        special_mode,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        pseudo_stop_enable,
  input  wire logic        pll_clock_select,
  // Analogue status
  input  wire logic        self_clock_mode_flag,
  input  wire logic        near_target,
  input  wire logic        pll_locked,
  input  wire logic        clock_lost,
  // PLL and monitor controls
  output logic             pll_power,
  output logic             pll_high_bandwidth,
  output logic             clock_monitor_active,
  output logic             clock_monitor_reset_req,
  output logic             self_clock_entry_req,
  // Timer dividers
  output logic             tick_timer_halt,
  output logic             tick_timer_div_clear,
  output logic             watchdog_halt,
  output logic             watchdog_div_clear,
  // Interrupt
  output logic             irq
);
  logic [7:0]  pll_control_q;
  logic [2:0]  wait_control_q;
  logic        watchdog_written_q;
  logic [pwc_pkg::PWC_EV_N-1:0] irq_status_q;
  logic [pwc_pkg::PWC_EV_N-1:0] irq_mask_q;
  logic [pwc_pkg::PWC_EV_N-1:0] events;
  logic        wait_q;
  logic        locked_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        wait_entry;
  logic        auto_eff;
  pwc_pkg::pwc_pmode_e pmode_q;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign addr_ok = hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS)
                 | hit(paddr, pwc_pkg::PWC_WAIT_CONTROL_OFS)
                 | hit(paddr, pwc_pkg::PWC_STATUS_OFS)
                 | hit(paddr, pwc_pkg::PWC_IRQ_STATUS_OFS)
                 | hit(paddr, pwc_pkg::PWC_IRQ_MASK_OFS);
  assign pslverr = psel & penable & ~addr_ok;

  // PLL control register; the monitor, power and automatic bits each have their own lock-out, the bandwidth, PSW and self-clock bits always take the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_control_q <= pwc_pkg::PWC_PLL_CONTROL_RST;
    end else begin
      if (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS)) begin
        if (!self_clock_mode_flag) begin
          pll_control_q[pwc_pkg::PWC_MON_BIT] <= pwdata[pwc_pkg::PWC_MON_BIT];
        end
        if (!pll_clock_select) begin
          pll_control_q[pwc_pkg::PWC_PON_BIT] <= pwdata[pwc_pkg::PWC_PON_BIT];
        end
        if (!wait_control_q[pwc_pkg::PWC_PWAI_BIT]) begin
          pll_control_q[pwc_pkg::PWC_AUTO_BIT] <= pwdata[pwc_pkg::PWC_AUTO_BIT];
        end
        pll_control_q[pwc_pkg::PWC_BW_BIT]   <= pwdata[pwc_pkg::PWC_BW_BIT];
        pll_control_q[pwc_pkg::PWC_PSW_BIT]  <= pwdata[pwc_pkg::PWC_PSW_BIT];
        pll_control_q[pwc_pkg::PWC_SELF_BIT] <= pwdata[pwc_pkg::PWC_SELF_BIT];
      end
      if (wait_control_q[pwc_pkg::PWC_PWAI_BIT]) begin
        pll_control_q[pwc_pkg::PWC_AUTO_BIT] <= 1'b1;
      end
    end
  end

  // Wait-stop controls; the watchdog bit is write-once outside special modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_control_q     <= pwc_pkg::PWC_WAIT_CONTROL_RST;
      watchdog_written_q <= 1'b0;
    end else if (wr_en && hit(paddr, pwc_pkg::PWC_WAIT_CONTROL_OFS)) begin
      wait_control_q[pwc_pkg::PWC_TTW_BIT]  <= pwdata[pwc_pkg::PWC_TTW_BIT];
      wait_control_q[pwc_pkg::PWC_PWAI_BIT] <= pwdata[pwc_pkg::PWC_PWAI_BIT];
      if (special_mode || !watchdog_written_q) begin
        wait_control_q[pwc_pkg::PWC_WDW_BIT] <= pwdata[pwc_pkg::PWC_WDW_BIT];
      end
      watchdog_written_q <= 1'b1;
    end
  end

  // Power mode tracking for wait entry detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmode_q  <= pwc_pkg::PWC_RUN;
      wait_q   <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      wait_q   <= wait_mode;
      locked_q <= pll_locked;
      case (pmode_q)
        pwc_pkg::PWC_RUN: begin
          if (stop_mode) begin
            pmode_q <= pwc_pkg::PWC_STOP;
          end else if (wait_mode) begin
            pmode_q <= pwc_pkg::PWC_WAIT;
          end
        end
        pwc_pkg::PWC_WAIT: begin
          if (stop_mode) begin
            pmode_q <= pwc_pkg::PWC_STOP;
          end else if (!wait_mode) begin
            pmode_q <= pwc_pkg::PWC_RUN;
          end
        end
        pwc_pkg::PWC_STOP: begin
          if (!stop_mode) begin
            pmode_q <= wait_mode ? pwc_pkg::PWC_WAIT : pwc_pkg::PWC_RUN;
          end
        end
        default: begin
          pmode_q <= pwc_pkg::PWC_RUN;
        end
      endcase
    end
  end
  assign wait_entry = wait_mode & ~wait_q;

  // Analogue controls
  assign pll_power = pll_control_q[pwc_pkg::PWC_PON_BIT] | self_clock_mode_flag;
  assign auto_eff  = pll_control_q[pwc_pkg::PWC_AUTO_BIT];
  // Automatic mode acquires far from target, tracks near it; locks with no software
  assign pll_high_bandwidth = auto_eff ? ~near_target
                                       : pll_control_q[pwc_pkg::PWC_BW_BIT];
  // Full stop kills the monitor; pseudo-stop leaves it to the enable bit
  assign clock_monitor_active = pll_control_q[pwc_pkg::PWC_MON_BIT]
                              & ~(stop_mode & ~pseudo_stop_enable);
  // Self-clock enable picks the loss response; otherwise a reset sequence
  assign self_clock_entry_req    = clock_monitor_active & clock_lost
                                 & pll_control_q[pwc_pkg::PWC_SELF_BIT];
  assign clock_monitor_reset_req = clock_monitor_active & clock_lost
                                 & ~pll_control_q[pwc_pkg::PWC_SELF_BIT];

  assign tick_timer_halt      = wait_mode & wait_control_q[pwc_pkg::PWC_TTW_BIT];
  assign tick_timer_div_clear = wait_entry & wait_control_q[pwc_pkg::PWC_TTW_BIT];
  assign watchdog_halt        = wait_mode & wait_control_q[pwc_pkg::PWC_WDW_BIT];
  assign watchdog_div_clear   = wait_entry & wait_control_q[pwc_pkg::PWC_WDW_BIT];

  // Interrupt status: set wins over a same-cycle clear
  always_comb begin
    events = '0;
    events[pwc_pkg::PWC_EV_LOSS] = clock_monitor_active & clock_lost;
    events[pwc_pkg::PWC_EV_LOCK] = pll_locked & ~locked_q;
    events[pwc_pkg::PWC_EV_WAIT] = wait_entry;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else if (wr_en && hit(paddr, pwc_pkg::PWC_IRQ_STATUS_OFS)) begin
      irq_status_q <= (irq_status_q & ~pwdata[pwc_pkg::PWC_EV_N-1:0]) | events;
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_en && hit(paddr, pwc_pkg::PWC_IRQ_MASK_OFS)) begin
      irq_mask_q <= pwdata[pwc_pkg::PWC_EV_N-1:0];
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // Read data registered in setup, so it is stable for the access phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS)) begin
      rdata_d[7:0] = pll_control_q;
    end else if (hit(paddr, pwc_pkg::PWC_WAIT_CONTROL_OFS)) begin
      rdata_d[2:0] = wait_control_q;
    end else if (hit(paddr, pwc_pkg::PWC_STATUS_OFS)) begin
      rdata_d[3:0] = {pll_locked, pll_high_bandwidth, clock_monitor_active, self_clock_mode_flag};
    end else if (hit(paddr, pwc_pkg::PWC_IRQ_STATUS_OFS)) begin
      rdata_d[pwc_pkg::PWC_EV_N-1:0] = irq_status_q;
    end else if (hit(paddr, pwc_pkg::PWC_IRQ_MASK_OFS)) begin
      rdata_d[pwc_pkg::PWC_EV_N-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_d;
    end
  end

  // Assertions
  a_mon_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS) && self_clock_mode_flag)
    |=> $stable(pll_control_q[pwc_pkg::PWC_MON_BIT]))
    else $error("monitor enable changed during self-clock");
  a_pon_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS) && pll_clock_select)
    |=> $stable(pll_control_q[pwc_pkg::PWC_PON_BIT]))
    else $error("pll power changed while pll clock selected");
  a_pon_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS) && !pll_clock_select)
    |=> pll_control_q[pwc_pkg::PWC_PON_BIT] == $past(pwdata[pwc_pkg::PWC_PON_BIT]))
    else $error("pll power write lost");
  a_self_force: assert property (@(posedge pclk) disable iff (!presetn)
    self_clock_mode_flag |-> pll_power)
    else $error("pll not forced on in self-clock");
  a_auto_force: assert property (@(posedge pclk) disable iff (!presetn)
    wait_control_q[pwc_pkg::PWC_PWAI_BIT] |=> pll_control_q[pwc_pkg::PWC_AUTO_BIT])
    else $error("automatic bit not forced");
  a_bw_manual: assert property (@(posedge pclk) disable iff (!presetn)
    !pll_control_q[pwc_pkg::PWC_AUTO_BIT]
    |-> pll_high_bandwidth == pll_control_q[pwc_pkg::PWC_BW_BIT])
    else $error("manual bandwidth mismatch");
  a_bw_auto: assert property (@(posedge pclk) disable iff (!presetn)
    pll_control_q[pwc_pkg::PWC_AUTO_BIT] |-> pll_high_bandwidth == !near_target)
    else $error("automatic bandwidth mismatch");
  a_stop_monitor: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_mode && !pseudo_stop_enable) |-> !clock_monitor_active && !clock_monitor_reset_req)
    else $error("monitor active in full stop");
  a_wdw_once: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_WAIT_CONTROL_OFS) && watchdog_written_q && !special_mode)
    |=> $stable(wait_control_q[pwc_pkg::PWC_WDW_BIT]))
    else $error("watchdog wait-stop rewritten");
  a_tick_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(wait_mode) && wait_control_q[pwc_pkg::PWC_TTW_BIT]) |-> tick_timer_div_clear)
    else $error("tick divider not cleared on wait entry");
  a_wdog_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (wait_mode && !wait_control_q[pwc_pkg::PWC_WDW_BIT]) |-> !watchdog_halt)
    else $error("watchdog halted while allowed to run");

  // Register writes that must land, and the automatic bit lock-out
  a_mon_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS) && !self_clock_mode_flag)
    |=> pll_control_q[pwc_pkg::PWC_MON_BIT] == $past(pwdata[pwc_pkg::PWC_MON_BIT]))
    else $error("monitor enable write lost");
  a_auto_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS) && wait_control_q[pwc_pkg::PWC_PWAI_BIT])
    |=> pll_control_q[pwc_pkg::PWC_AUTO_BIT])
    else $error("automatic bit cleared while locked");
  a_acq_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS))
    |=> pll_control_q[pwc_pkg::PWC_BW_BIT] == $past(pwdata[pwc_pkg::PWC_BW_BIT]))
    else $error("acquisition write lost");
  a_other_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_PLL_CONTROL_OFS) && self_clock_mode_flag)
    |=> pll_control_q[pwc_pkg::PWC_SELF_BIT] == $past(pwdata[pwc_pkg::PWC_SELF_BIT]))
    else $error("unlocked bit dropped with locked one");
  a_wdw_first: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_WAIT_CONTROL_OFS) && (special_mode || !watchdog_written_q))
    |=> wait_control_q[pwc_pkg::PWC_WDW_BIT] == $past(pwdata[pwc_pkg::PWC_WDW_BIT]))
    else $error("watchdog wait-stop write lost");
  a_ttw_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_WAIT_CONTROL_OFS))
    |=> wait_control_q[pwc_pkg::PWC_TTW_BIT] == $past(pwdata[pwc_pkg::PWC_TTW_BIT]))
    else $error("tick timer wait-stop write lost");

  // Timer stops in wait mode, and stop-mode tracking
  a_tick_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (wait_mode && wait_control_q[pwc_pkg::PWC_TTW_BIT]) |-> tick_timer_halt)
    else $error("tick timer not halted in wait");
  a_tick_run: assert property (@(posedge pclk) disable iff (!presetn)
    !(wait_mode && wait_control_q[pwc_pkg::PWC_TTW_BIT])
    |-> !tick_timer_halt && !tick_timer_div_clear)
    else $error("tick timer halted while allowed to run");
  a_wdog_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (wait_mode && wait_control_q[pwc_pkg::PWC_WDW_BIT]) |-> watchdog_halt)
    else $error("watchdog not halted in wait");
  a_wdog_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(wait_mode) && wait_control_q[pwc_pkg::PWC_WDW_BIT]) |-> watchdog_div_clear)
    else $error("watchdog divider not cleared on wait entry");
  a_pmode_stop: assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode |=> pmode_q == pwc_pkg::PWC_STOP)
    else $error("power mode not tracking stop");

  // Monitor and PLL outputs
  a_loss_response: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_monitor_active && clock_lost) |-> self_clock_entry_req != clock_monitor_reset_req)
    else $error("clock loss response not exactly one");
  a_no_monitor: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_monitor_active |-> !self_clock_entry_req && !clock_monitor_reset_req)
    else $error("loss reported with monitor off");
  a_pseudo_monitor: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_mode && pseudo_stop_enable)
    |-> clock_monitor_active == pll_control_q[pwc_pkg::PWC_MON_BIT])
    else $error("monitor not following enable in pseudo stop");
  a_pon_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !self_clock_mode_flag |-> pll_power == pll_control_q[pwc_pkg::PWC_PON_BIT])
    else $error("pll power not following its bit");

  // Interrupt status and read path
  a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit(paddr, pwc_pkg::PWC_IRQ_STATUS_OFS))
    |=> (irq_status_q & $past(irq_status_q)) == $past(irq_status_q))
    else $error("status bit lost without clear");
  a_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, pwc_pkg::PWC_IRQ_STATUS_OFS) && events == '0)
    |=> (irq_status_q & $past(pwdata[pwc_pkg::PWC_EV_N-1:0])) == '0)
    else $error("status bit not cleared by one");
  a_event_set: assert property (@(posedge pclk) disable iff (!presetn)
    (|events) |=> (irq_status_q & $past(events)) == $past(events))
    else $error("event did not set status");
  a_lock_event: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pll_locked) |=> irq_status_q[pwc_pkg::PWC_EV_LOCK])
    else $error("lock rise not recorded");
  a_rdata_load: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en |=> prdata == $past(rdata_d))
    else $error("read data not loaded in setup");
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the PLL and wait-mode clock control block.
// Assumes pwc_pkg is compiled first; bench drives APB and all mode inputs itself.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, x;
  logic        special_mode, wait_mode, stop_mode, pseudo_stop_enable, pll_clock_select;
  logic        self_clock_mode_flag, near_target, pll_locked, clock_lost, pll_power;
  logic        pll_high_bandwidth, clock_monitor_active, clock_monitor_reset_req;
  logic        self_clock_entry_req, tick_timer_halt, tick_timer_div_clear;
  logic        watchdog_halt, watchdog_div_clear;
  logic [7:0]  pc, m;
  logic [1:0]  v;
  int          num_errors, comparisons, seed;

  pwc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .special_mode(special_mode), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .pseudo_stop_enable(pseudo_stop_enable),
    .pll_clock_select(pll_clock_select), .self_clock_mode_flag(self_clock_mode_flag),
    .near_target(near_target), .pll_locked(pll_locked), .clock_lost(clock_lost),
    .pll_power(pll_power), .pll_high_bandwidth(pll_high_bandwidth),
    .clock_monitor_active(clock_monitor_active),
    .clock_monitor_reset_req(clock_monitor_reset_req),
    .self_clock_entry_req(self_clock_entry_req), .tick_timer_halt(tick_timer_halt),
    .tick_timer_div_clear(tick_timer_div_clear), .watchdog_halt(watchdog_halt),
    .watchdog_div_clear(watchdog_div_clear), .irq(irq));

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Waits on pready even though it is tied high, so a stuck slave shows up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results;
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    results();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {special_mode, wait_mode, stop_mode, pseudo_stop_enable, pll_clock_select} = '0;
    {self_clock_mode_flag, near_target, pll_locked, clock_lost} = '0;
    seed = 58;
    presetn = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, pwc_pkg::PWC_PLL_CONTROL_OFS, 0);
    chk(rd, 32'h0000_00f1);
    chk({pll_power, clock_monitor_active}, 2'b11);
    tend("reset");
    // Normal mode: only the first write reaches the watchdog stop bit
    apb(1, pwc_pkg::PWC_WAIT_CONTROL_OFS, 32'h0000_0003);
    apb(1, pwc_pkg::PWC_WAIT_CONTROL_OFS, 32'h0000_0000);
    apb(0, pwc_pkg::PWC_WAIT_CONTROL_OFS, 0);
    chk(rd, 32'h0000_0001);
    special_mode <= 1;
    apb(1, pwc_pkg::PWC_WAIT_CONTROL_OFS, 32'h0000_0002);
    apb(0, pwc_pkg::PWC_WAIT_CONTROL_OFS, 0);
    chk(rd, 32'h0000_0002);
    tend("write_once");
    for (int i = 0; i < 2; i++) begin
      v = i ? 2'b00 : 2'b11;
      apb(1, pwc_pkg::PWC_WAIT_CONTROL_OFS, {30'h0, v});
      wait_mode <= 1;
      #1 chk({tick_timer_halt, tick_timer_div_clear, watchdog_halt, watchdog_div_clear},
        {v[1], v[1], v[0], v[0]});
      @(posedge pclk);
      #1 chk({tick_timer_halt, tick_timer_div_clear, watchdog_halt, watchdog_div_clear},
        {v[1], 1'b0, v[0], 1'b0});
      @(posedge pclk);
      wait_mode <= 0;
      @(posedge pclk);
    end
    tend("wait_stop");
    stop_mode <= 1;
    clock_lost <= 1;
    @(posedge pclk);
    #1 chk({clock_monitor_active, clock_monitor_reset_req, self_clock_entry_req}, 0);
    @(posedge pclk);
    pseudo_stop_enable <= 1;
    @(posedge pclk);
    #1 chk({clock_monitor_active, clock_monitor_reset_req, self_clock_entry_req}, 5);
    @(posedge pclk);
    apb(1, pwc_pkg::PWC_PLL_CONTROL_OFS, 32'h0000_00f0);
    chk({clock_monitor_active, clock_monitor_reset_req, self_clock_entry_req}, 6);
    stop_mode <= 0;
    clock_lost <= 0;
    pc = 8'hf0;
    tend("monitor");
    // Random lock conditions around every write, checked against a bit-level model
    repeat (40) begin
      x = $random(seed);
      self_clock_mode_flag <= x[0];
      pll_clock_select <= x[1];
      near_target <= x[2];
      apb(1, pwc_pkg::PWC_WAIT_CONTROL_OFS, {29'h0, x[3], 2'b00});
      if (x[3]) pc[5] = 1'b1;
      apb(1, pwc_pkg::PWC_PLL_CONTROL_OFS, {24'h0, x[15:8]});
      m = pwc_pkg::PWC_PLL_CONTROL_WMASK & ~{x[0], x[1], x[3], 5'h00};
      pc = (pc & ~m) | (x[15:8] & m);
      apb(0, pwc_pkg::PWC_PLL_CONTROL_OFS, 0);
      chk(rd, {24'h0, pc});
      chk(pll_power, pc[6] | x[0]);
      chk(pll_high_bandwidth, pc[5] ? !x[2] : pc[4]);
    end
    tend("random_locks");
    apb(1, pwc_pkg::PWC_IRQ_STATUS_OFS, 32'h0000_0007);
    apb(1, pwc_pkg::PWC_IRQ_MASK_OFS, 32'h0000_0002);
    chk(irq, 0);
    pll_locked <= 1;
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(0, pwc_pkg::PWC_IRQ_STATUS_OFS, 0);
    chk(rd, 32'h0000_0002);
    apb(1, pwc_pkg::PWC_IRQ_MASK_OFS, 32'h0000_0000);
    chk(irq, 0);
    apb(1, pwc_pkg::PWC_IRQ_MASK_OFS, 32'h0000_0002);
    chk(irq, 1);
    apb(1, pwc_pkg::PWC_IRQ_STATUS_OFS, 32'h0000_0002);
    chk(irq, 0);
    apb(0, 12'h020, 0);
    chk(err, 1);
    chk(rd, 32'h0000_0000);
    chk(pready, 1);
    tend("interrupt_and_unmapped");
    results();
  end
endmodule
`default_nettype wire
